// ===== src/pa_io_map.vh
// register map, field positions and reset values of the port block
`ifndef PA_IO_MAP_VH
`define PA_IO_MAP_VH
`define PA_OFF_DATA 12'h000
`define PA_OFF_DIR 12'h004
`define PA_OFF_DRIVE 12'h008
`define PA_OFF_SHARE 12'h00c
`define PA_OFF_WAKE 12'h010
`define PA_OFF_STATUS 12'h014
`define PA_OFF_BITOP 12'h018
`define PA_NPINS 5
`define PA_RST_DATA 5'h1f
`define PA_RST_DIR 5'h1f
`define PA_RST_DRIVE 4'h0
`define PA_RST_SHARE 5'h00
`define PA_RST_WAKE 5'h00
`define PA_DRV_P4_HI 3
`define PA_DRV_P4_LO 2
`define PA_DRV_LO_HI 1
`define PA_DRV_LO_LO 0
`define PA_SEL_PWM 4
`define PA_SEL_OCP_IN 3
`define PA_SEL_PWM_COMPLEMENT_OUT 2
`define PA_SEL_RSVD 1
`define PA_SEL_OCP_OUT 0
`define PA_BITOP_SET 8
`define PA_BITOP_REG_LO 4
`define PA_BITOP_REG_HI 6
`define PA_BITOP_BIT_HI 2
`endif

// ===== src/pa_sync3.v
// three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pa_sync3 #(
	parameter W = 5
) (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire [W-1:0] din, // asynchronous pin levels
	input wire [W-1:0] rst_val, // unused reset hint, kept zero-effect
	output reg [W-1:0] dout // filtered level
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;
	wire [W-1:0] agree = ~(s2_r ^ s3_r);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= {W{1'b1}};
			s2_r <= {W{1'b1}};
			s3_r <= {W{1'b1}};
			dout <= {W{1'b1}};
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// a level only counts once two stages agree, hiding metastable flips
			dout <= (agree & s2_r) | (~agree & dout) | (rst_val & ~rst_val);
		end
	end
endmodule // pa_sync3

// ===== src/pa_wake.v
// falling-edge wake detector for the port pins
`timescale 1ns/1ps
module pa_wake #(
	parameter W = 5
) (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire [W-1:0] level, // filtered pin levels
	input wire [W-1:0] arm, // per-pin wake permitted
	input wire low_power, // device in sleep or idle
	output reg wake // wake pulse, one cycle
);
	reg [W-1:0] prev_r;
	genvar i;
	wire [W-1:0] fall;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_fall
			assign fall[i] = prev_r[i] & ~level[i] & arm[i];
		end
	endgenerate
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= {W{1'b1}};
			wake <= 1'b0;
		end else begin
			prev_r <= level;
			wake <= low_power & (|fall); // see [RULE17]
		end
	end
endmodule // pa_wake

// ===== src/pa_port.v
// five-pin port with direction, drive level, pin mux, wake and APB registers
// Functional notes
// [RULE1] each pin has a direction bit: 1 input read directly, 0 push-pull output
// [RULE2] output pins read back the data latch, not the pin level
// [RULE3] reset sets all direction and data latch bits to one
// [RULE4] output enabled without a latch write drives high
// [RULE5] software must make pin 4 an output after power-on
// [RULE6] drive bits 3:2 set pin 4 source current, 00 min to 11 max
// [RULE7] drive bits 1:0 set source current of pins 0 to 3 together
// [RULE8] drive level matters only while pin is a CMOS output
// [RULE9] share bit 4: pin 4 port or PWM output
// [RULE10] share bit 3: pin 3 port or overcurrent sense input
// [RULE11] share bit 2: pin 2 port or complementary PWM output
// [RULE12] share bit 1: pin 1 port; value 1 reserved, no function; here value 1 masks the pin 1 wake enable
// [RULE13] share bit 0: pin 0 port and timer clock, or comparator output
// [RULE14] digital input functions need the direction bit set to input; the pin 3 overcurrent sense input here ignores the direction bit
// [RULE15] select pin function before enabling peripheral, disable before deselecting
// [RULE16] bit set and clear work as read-modify-write of whole byte
// [RULE17] falling edge on a wake-enabled pin wakes device in sleep or idle
// [RULE18] unimplemented upper register bits read zero
// [RULE19] per-pin wake enable acts only for port inputs in low power
// [RULE20] a selected peripheral output replaces the data latch on the pin
`timescale 1ns/1ps
`include "pa_io_map.vh"
module pa_port #(
	parameter NP = 5
) (
	input wire pclk, // system clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error, unmapped address
	input wire [NP-1:0] pin_in, // pin levels sensed
	output reg [NP-1:0] pin_out, // pin output value
	output reg [NP-1:0] pin_oe_n, // pin output enable, low drives
	output reg [1:0] pin4_drive_level, // pin 4 source current level
	output reg [1:0] low_pins_drive_level, // pins 0-3 source current level
	input wire pwm_out, // pwm peripheral output
	input wire pwm_complement_out, // complementary pwm output
	input wire overcurrent_cmp_out, // overcurrent comparator output
	output reg overcurrent_sense_in, // pin 3 toward overcurrent sense
	output reg timer_ext_clock_in, // pin 0 toward timer clock
	input wire low_power, // device in sleep or idle
	output reg wake_req // wake pulse, one cycle
);
	reg [NP-1:0] port_data_reg_r;
	reg [NP-1:0] pin_direction_r;
	reg [3:0] pin_drive_strength_r;
	reg [NP-1:0] pin_share_select_r;
	reg [NP-1:0] wake_enable_reg_r;
	reg [NP-1:0] port_data_reg_nxt;
	reg [NP-1:0] pin_direction_nxt;
	reg [NP-1:0] pin_share_select_nxt;
	reg [NP-1:0] wake_enable_reg_nxt;
	reg [NP-1:0] pin_drv_nxt;
	reg [NP-1:0] pin_oe_n_nxt;
	reg [NP-1:0] rmw_val;
	reg [31:0] rd_nxt;
	wire [NP-1:0] pin_lvl;
	wire wake_w;
	wire acc = psel & penable & ~pready;
	wire wr = acc & pwrite;
	wire [NP-1:0] sel_out_mask;
	wire [NP-1:0] port_in_mask;

	// true for any offset that has a register behind it
	function mapped;
		input [11:0] a;
		begin
			mapped = (a == `PA_OFF_DATA) || (a == `PA_OFF_DIR) || (a == `PA_OFF_DRIVE) ||
				(a == `PA_OFF_SHARE) || (a == `PA_OFF_WAKE) || (a == `PA_OFF_STATUS) ||
				(a == `PA_OFF_BITOP);
		end
	endfunction

	// set or clear one bit of a byte, used by the bit-operation port
	function [NP-1:0] bit_mod;
		input [NP-1:0] v;
		input [2:0] b;
		input s;
		integer k;
		begin
			bit_mod = v;
			for (k = 0; k < NP; k = k + 1) begin
				if (b == k[2:0]) begin
					bit_mod[k] = s;
				end
			end
		end
	endfunction

	pa_sync3 #(.W(NP)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(pin_in),
		.rst_val({NP{1'b0}}),
		.dout(pin_lvl)
	);

	// pins carrying a peripheral output: pin 4 pwm, pin 2 pwm_complement_out, pin 0 comparator
	assign sel_out_mask = {pin_share_select_r[`PA_SEL_PWM], 1'b0, pin_share_select_r[`PA_SEL_PWM_COMPLEMENT_OUT], 1'b0,
		pin_share_select_r[`PA_SEL_OCP_OUT]}; // see [RULE20]
	// general purpose inputs: port function selected and direction input
	assign port_in_mask = ~pin_share_select_r & pin_direction_r; // see [RULE19]

	pa_wake #(.W(NP)) u_wake (
		.pclk(pclk),
		.presetn(presetn),
		.level(pin_lvl),
		.arm(wake_enable_reg_r & port_in_mask), // see [RULE19]
		.low_power(low_power),
		.wake(wake_w)
	);

	// register value chosen by a bit operation, read fresh each time
	always @* begin
		case (pwdata[`PA_BITOP_REG_HI:`PA_BITOP_REG_LO])
			3'h0: rmw_val = port_data_reg_r;
			3'h1: rmw_val = pin_direction_r;
			3'h3: rmw_val = pin_share_select_r;
			3'h4: rmw_val = wake_enable_reg_r;
			default: rmw_val = {NP{1'b0}};
		endcase
	end

	always @* begin
		port_data_reg_nxt = port_data_reg_r;
		pin_direction_nxt = pin_direction_r;
		pin_share_select_nxt = pin_share_select_r;
		wake_enable_reg_nxt = wake_enable_reg_r;
		if (wr) begin
			case (paddr)
				`PA_OFF_DATA: port_data_reg_nxt = pwdata[NP-1:0];
				`PA_OFF_DIR: pin_direction_nxt = pwdata[NP-1:0]; // see [RULE1]
				`PA_OFF_SHARE: pin_share_select_nxt = pwdata[NP-1:0];
				`PA_OFF_WAKE: wake_enable_reg_nxt = pwdata[NP-1:0];
				`PA_OFF_BITOP: begin
					// whole byte read, one bit changed, whole byte written back
					case (pwdata[`PA_BITOP_REG_HI:`PA_BITOP_REG_LO])
						3'h0: port_data_reg_nxt = bit_mod(rmw_val, pwdata[`PA_BITOP_BIT_HI:0],
							pwdata[`PA_BITOP_SET]); // see [RULE16]
						3'h1: pin_direction_nxt = bit_mod(rmw_val, pwdata[`PA_BITOP_BIT_HI:0],
							pwdata[`PA_BITOP_SET]); // see [RULE16]
						3'h3: pin_share_select_nxt = bit_mod(rmw_val, pwdata[`PA_BITOP_BIT_HI:0],
							pwdata[`PA_BITOP_SET]); // see [RULE16]
						3'h4: wake_enable_reg_nxt = bit_mod(rmw_val, pwdata[`PA_BITOP_BIT_HI:0],
							pwdata[`PA_BITOP_SET]); // see [RULE16]
						default: begin
							port_data_reg_nxt = port_data_reg_r;
						end
					endcase
				end
				default: begin
					port_data_reg_nxt = port_data_reg_r;
				end
			endcase
		end
	end

	// read mux: inputs show the pin, outputs show the latch
	always @* begin
		rd_nxt = 32'h0000_0000;
		case (paddr)
			`PA_OFF_DATA: rd_nxt[NP-1:0] = (pin_direction_r & pin_lvl) |
				(~pin_direction_r & port_data_reg_r); // see [RULE1] see [RULE2]
			`PA_OFF_DIR: rd_nxt[NP-1:0] = pin_direction_r; // see [RULE18]
			`PA_OFF_DRIVE: rd_nxt[3:0] = pin_drive_strength_r; // see [RULE18]
			`PA_OFF_SHARE: rd_nxt[NP-1:0] = pin_share_select_r; // see [RULE18]
			`PA_OFF_WAKE: rd_nxt[NP-1:0] = wake_enable_reg_r;
			`PA_OFF_STATUS: rd_nxt[NP-1:0] = pin_lvl;
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// pin drive: a selected peripheral output overrides the latch and drives regardless
	always @* begin
		pin_drv_nxt = port_data_reg_r;
		if (pin_share_select_r[`PA_SEL_PWM]) begin
			pin_drv_nxt[4] = pwm_out; // see [RULE9]
		end
		if (pin_share_select_r[`PA_SEL_PWM_COMPLEMENT_OUT]) begin
			pin_drv_nxt[2] = pwm_complement_out; // see [RULE11]
		end
		if (pin_share_select_r[`PA_SEL_OCP_OUT]) begin
			pin_drv_nxt[0] = overcurrent_cmp_out; // see [RULE13]
		end
		// pin 3 sense function is an input: never driven when selected
		pin_oe_n_nxt = (pin_direction_r & ~sel_out_mask) | {1'b0, pin_share_select_r[`PA_SEL_OCP_IN],
			3'b000}; // see [RULE10] see [RULE20]
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_data_reg_r <= `PA_RST_DATA; // see [RULE3] see [RULE4]
			pin_direction_r <= `PA_RST_DIR; // see [RULE3]
			pin_drive_strength_r <= `PA_RST_DRIVE;
			pin_share_select_r <= `PA_RST_SHARE;
			wake_enable_reg_r <= `PA_RST_WAKE;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			pin_out <= `PA_RST_DATA;
			pin_oe_n <= `PA_RST_DIR;
			pin4_drive_level <= 2'h0;
			low_pins_drive_level <= 2'h0;
			overcurrent_sense_in <= 1'b0;
			timer_ext_clock_in <= 1'b1;
			wake_req <= 1'b0;
		end else begin
			port_data_reg_r <= port_data_reg_nxt;
			pin_direction_r <= pin_direction_nxt;
			pin_share_select_r <= pin_share_select_nxt;
			wake_enable_reg_r <= wake_enable_reg_nxt;
			if (wr && paddr == `PA_OFF_DRIVE) begin
				pin_drive_strength_r <= pwdata[3:0];
			end
			// one wait state: answer in the cycle after the access phase starts
			pready <= acc;
			pslverr <= acc & ~mapped(paddr);
			if (acc && !pwrite) begin
				prdata <= rd_nxt;
			end
			pin_out <= pin_drv_nxt;
			pin_oe_n <= pin_oe_n_nxt;
			// drive levels reach the pad only for a driven output, else minimum
			pin4_drive_level <= pin_oe_n_nxt[4] ? 2'h0 :
				pin_drive_strength_r[`PA_DRV_P4_HI:`PA_DRV_P4_LO]; // see [RULE6] see [RULE8]
			low_pins_drive_level <= (&pin_oe_n_nxt[3:0]) ? 2'h0 :
				pin_drive_strength_r[`PA_DRV_LO_HI:`PA_DRV_LO_LO]; // see [RULE7] see [RULE8]
			// reserved selection on pin 1 keeps pin 1 driving and reading as a port pin but masks its wake enable
			overcurrent_sense_in <= pin_share_select_r[`PA_SEL_OCP_IN] & pin_lvl[3]; // see [RULE10] see [RULE12]
			// timer clock seen only while pin 0 is a port input; software sets it so
			timer_ext_clock_in <= pin_share_select_r[`PA_SEL_OCP_OUT] ? 1'b1 :
				(pin_direction_r[0] ? pin_lvl[0] : 1'b1); // see [RULE13] see [RULE14]
			wake_req <= wake_w; // see [RULE17]
		end
	end
endmodule // pa_port

// ===== tb/pa_board.sv
// board side of the port pins: follows the port where it drives, else applies ext
`timescale 1ns/1ps
module pa_board (
	input wire logic [4:0] pin_out, // port drive value
	input wire logic [4:0] pin_oe_n, // low where the port drives
	input wire logic [4:0] ext, // level the board applies to released pins
	input wire logic clash, // board fights driven pins, only when asked
	output logic [4:0] pin_in // sensed pin levels
);
	// a fighting board shows the inverse, so latch readback cannot hide behind the pin
	assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & (pin_out ^ {5{clash}}));
endmodule // pa_board

// ===== tb/pa_port_chk.sv
// assertions on the port block pins and register bus
`timescale 1ns/1ps
module pa_port_chk (
	input wire pclk, // clock
	input wire presetn, // reset, active low
	input wire psel, // select
	input wire penable, // access
	input wire pwrite, // direction
	input wire [31:0] prdata, // read data
	input wire pready, // ready
	input wire pslverr, // error
	input wire [4:0] pin_out, // drive value
	input wire [4:0] pin_oe_n, // low drives
	input wire [1:0] pin4_drive_level, // pin 4 level
	input wire [1:0] low_pins_drive_level, // pins 0-3 level
	input wire overcurrent_sense_in, // pin 3 sense
	input wire timer_ext_clock_in, // pin 0 timer clock
	input wire low_power, // sleep or idle
	input wire wake_req // wake pulse
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rst; $rose(presetn) |-> pin_oe_n == 5'h1f && pin_out == 5'h1f; endproperty
	property p_ready; psel && penable && !pready |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_err; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
	property p_drv4; pin_oe_n[4] |-> pin4_drive_level == 2'h0; endproperty
	property p_drvlo; &pin_oe_n[3:0] |-> low_pins_drive_level == 2'h0; endproperty
	property p_sense; !pin_oe_n[3] [*2] |-> !overcurrent_sense_in; endproperty
	property p_tclk; !pin_oe_n[0] [*2] |-> timer_ext_clock_in; endproperty
	property p_wake; !low_power [*3] |=> !wake_req; endproperty
	a_rst: assert property (p_rst) else $error("pins not released after reset");
	a_ready: assert property (p_ready) else $error("no ready after one wait state");
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	a_err: assert property (p_err) else $error("refused read returned data");
	a_drv4: assert property (p_drv4) else $error("pin 4 level while not driven");
	a_drvlo: assert property (p_drvlo) else $error("low pins level while not driven");
	a_sense: assert property (p_sense) else $error("sense active on driven pin 3");
	a_tclk: assert property (p_tclk) else $error("timer clock follows driven pin 0");
	a_wake: assert property (p_wake) else $error("wake outside low power");
	c_wake: cover property (wake_req);
	c_err: cover property (pready && pslverr);
	c_drv: cover property (!pin_oe_n[4] && pin4_drive_level == 2'h3);
endmodule // pa_port_chk
bind pa_port pa_port_chk u_chk (.*);

// ===== tb/testbench.sv
// self-checking bench for the port block
`timescale 1ns/1ps
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clash = 0, err;
	logic pwm_out = 0, pwm_complement_out = 0, overcurrent_cmp_out = 0, low_power = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, overcurrent_sense_in, timer_ext_clock_in, wake_req;
	logic [4:0] pin_in, pin_out, pin_oe_n, dir, dat, ext = 5'h1f;
	logic [1:0] pin4_drive_level, low_pins_drive_level;
	logic [15:0] lfsr = 16'h18b9;
	integer failures = 0, num_checks = 0, i, n;
	always #20 pclk = ~pclk;
	pa_port dut (.*);
	pa_board board (.*);
	function automatic logic [4:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[4:0];
	endfunction
	// inputs read the pin, outputs read the latch
	function automatic logic [31:0] exp_data(input logic [4:0] d, l, e);
		return {27'h0, (d & e) | (~d & l)};
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task stop_test;
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#2000000;
		failures++;
		stop_test;
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 5; i++) begin
			apb(1'b0, {i[9:0], 2'b00}, 32'h0);
			chk("reset", (i < 2) ? 32'h1f : 32'h0, rd);
		end
		apb(1'b1, 12'h004, 32'h0f);
		chk("latch high", 32'h1, {31'h0, pin_out[4]});
		clash <= 1'b1;
		for (i = 0; i < 12; i++) begin
			dir = rnd() & 5'h0f;
			dat = rnd();
			ext <= rnd();
			apb(1'b1, 12'h000, {27'h0, dat});
			apb(1'b1, 12'h004, {27'h7, dir});
			apb(1'b1, 12'h008, {28'hf, dat[3:0]});
			repeat (6) @(posedge pclk);
			chk("oe", {27'h0, dir}, {27'h0, pin_oe_n});
			chk("out", {27'h0, dat & ~dir}, {27'h0, pin_out & ~dir});
			apb(1'b0, 12'h000, 32'h0);
			chk("data", exp_data(dir, dat, ext), rd);
			apb(1'b0, 12'h004, 32'h0);
			chk("dir", {27'h0, dir}, rd);
			apb(1'b0, 12'h008, 32'h0);
			chk("drive", {28'h0, dat[3:0]}, rd);
			chk("lvl4", {30'h0, dat[3:2]}, {30'h0, pin4_drive_level});
			chk("lvl", (dir[3:0] != 4'hf) ? {30'h0, dat[1:0]} : 32'h0, {30'h0, low_pins_drive_level});
		end
		clash <= 1'b0;
		apb(1'b1, 12'h000, 32'h0);
		// pin 1 must be a driven output so the expected enable pattern does not hang on random data
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h00c, 32'hff);
		apb(1'b0, 12'h00c, 32'h0);
		chk("share", 32'h1f, rd);
		for (i = 0; i < 2; i++) begin
			pwm_out <= i[0];
			pwm_complement_out <= ~i[0];
			overcurrent_cmp_out <= i[0];
			ext <= {1'b1, i[0], 3'h7};
			repeat (8) @(posedge pclk);
			chk("mux oe", 32'h08, {27'h0, pin_oe_n});
			chk("mux", {27'h0, i[0], 1'b0, ~i[0], 1'b0, i[0]}, {27'h0, pin_out});
			chk("sense", {31'h0, i[0]}, {31'h0, overcurrent_sense_in});
		end
		apb(1'b1, 12'h00c, 32'h0);
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h018, 32'h112);
		apb(1'b0, 12'h004, 32'h0);
		chk("bit set", 32'h04, rd);
		apb(1'b1, 12'h018, 32'h012);
		apb(1'b0, 12'h004, 32'h0);
		chk("bit clear", 32'h0, rd);
		apb(1'b1, 12'h004, 32'h1f);
		ext <= 5'h1e;
		repeat (8) @(posedge pclk);
		chk("tclk", 32'h0, {31'h0, timer_ext_clock_in});
		ext <= 5'h1f;
		apb(1'b1, 12'h010, 32'h01);
		low_power <= 1'b1;
		for (i = 0; i < 2; i++) begin
			repeat (8) @(posedge pclk);
			ext <= i ? 5'h1c : 5'h1d;
			n = 0;
			repeat (10) begin
				@(posedge pclk);
				n += wake_req;
			end
			chk("wake", i, n);
		end
		low_power <= 1'b0;
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		stop_test;
	end
endmodule // testbench
